// ---- hw/serial_slave_error_screening.sv ----
// request screening and error reporting for a serial register slave
// Summary of operation
// RL1: non-consecutive read over 120 bytes gives count error
// RL2: non-consecutive write over 60 bytes gives count error
// RL3: out-of-range setting gives code 21
// RL4: run-locked write while running gives 22
// RL5: control fault allows only setup items
// RL6: write to read-only item gives 22
// RL7: undervoltage-locked write gives code 23
// RL8: write during parameter processing gives 24
// RL9: nonvolatile store while disabled gives 25
// RL10: code 25 shows message, drive keeps running
// RL11: link or checksum error discards silently
// RL12: foreign address is ignored silently
// RL13: character gap over 24 bits discards
// RL14: length mismatch discards silently
// RL15: broadcast executes with no reply
// RL16: last error code and type readable
// RL17: unknown function code gives code 01
// RL18: undefined register gives code 02
// RL19: broadcast start not 1 or 2 gives 02
// RL20: checked failure answers with error code
`timescale 1ns/10ps
`include "serial_screen_defs.svh"
module serial_slave_error_screening
    import serial_screen_pkg::*;
#(
    parameter int BAUD_RATE = `SCR_BAUD_DEFAULT,
    parameter int GAP_CYCLES = `SCR_GAP_BITS * (`SCR_CLK_HZ / BAUD_RATE)
) (
    input wire logic clk_sys,
    input wire logic rst,
    // character and frame events from the framing logic
    input wire logic charStrobe,
    input wire logic charError,
    input wire logic frameDone,
    input wire logic crcOk,
    input wire logic lengthOk,
    // decoded frame fields
    input wire logic [7:0] slaveAddr,
    input wire logic [7:0] funcCode,
    input wire logic [15:0] startReg,
    input wire logic [7:0] regCount,
    input wire logic [7:0] byteCount,
    input wire logic nonConsecutive,
    // attributes of the addressed item
    input wire logic regDefined,
    input wire logic regReadOnly,
    input wire logic regRunLocked,
    input wire logic regUvLocked,
    input wire logic regSetupItem,
    input wire logic valueInRange,
    input wire logic nvStoreCmd,
    // drive state
    input wire logic [7:0] nodeAddress,
    input wire logic motorRunning,
    input wire logic controlCircuitFault,
    input wire logic dcBusUndervoltage,
    input wire logic paramBusy,
    input wire logic nvWriteDisabled,
    input wire logic nvWarnAck,
    // answers
    output logic respValid,
    output logic respIsError,
    output logic [7:0] respCode,
    output logic execStrobe,
    output logic discardStrobe,
    output logic [7:0] commErrCode,
    output logic [1:0] commErrType,
    output logic nvWarnMsg
);
    localparam int CNT_W = $clog2(GAP_CYCLES + 2);

    // ====================================================
    // frame tracking state
    rx_state_type state_ff, nxt_state;
    logic charErrSeen_ff, nxt_charErrSeen; // line error seen this frame
    logic gapSeen_ff, nxt_gapSeen; // overlong gap seen this frame
    logic gapOver; // gap timer beyond limit

    // character gap counter
    gap_timer #(.LIMIT(GAP_CYCLES), .CNT_W(CNT_W)) u_gap (
        .clk_sys(clk_sys),
        .rst(rst),
        .charStrobe(charStrobe),
        .frameActive(state_ff == RX_BUSY),
        .gapOver(gapOver)
    );

    // next frame tracking values
    always_comb begin
        nxt_state = state_ff;
        nxt_charErrSeen = charErrSeen_ff;
        nxt_gapSeen = gapSeen_ff;
        unique case (state_ff)
            RX_IDLE: begin
                if (charStrobe && !frameDone) begin
                    nxt_state = RX_BUSY;
                    nxt_charErrSeen = charError;
                end
            end
            RX_BUSY: begin
                if (frameDone) begin
                    // flags were used this cycle, start clean
                    nxt_state = RX_IDLE;
                    nxt_charErrSeen = 1'b0;
                    nxt_gapSeen = 1'b0;
                end else if (charStrobe) begin
                    nxt_charErrSeen = charErrSeen_ff | charError;
                    // RL13 gap check at each character
                    nxt_gapSeen = gapSeen_ff | gapOver;
                end
            end
        endcase
    end

    // register frame tracking
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_ff <= RX_IDLE;
            charErrSeen_ff <= 1'b0;
            gapSeen_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            charErrSeen_ff <= nxt_charErrSeen;
            gapSeen_ff <= nxt_gapSeen;
        end
    end

    // ====================================================
    // screening decision
    logic lineBad; // silent-discard cause present
    logic isBcast; // frame sent to every slave
    logic addrHit; // frame for this slave
    logic isWrite; // write function
    logic [8:0] readBytes; // bytes a read would return
    logic [7:0] errCode; // chosen error code

    // a same-cycle character error counts together with the sticky flags
    // RL11 line, framing and checksum errors
    assign lineBad = charErrSeen_ff | (charStrobe & charError) | !crcOk
        // RL13 gap flagged during the frame
        | gapSeen_ff
        // RL14 declared length disagrees
        | !lengthOk;
    // RL12 address compare
    assign isBcast = (slaveAddr == `SCR_BCAST_ADDR);
    assign addrHit = (slaveAddr == nodeAddress) | isBcast;
    assign isWrite = (funcCode == `SCR_FC_WRITE);
    assign readBytes = {regCount, 1'b0};

    // error code in order of precedence
    always_comb begin
        errCode = `SCR_ERR_NONE;
        if (funcCode != `SCR_FC_READ && funcCode != `SCR_FC_LOOP && !isWrite) begin
            // RL17 unknown function
            errCode = `SCR_ERR_FUNC;
        end else if (funcCode == `SCR_FC_LOOP) begin
            errCode = `SCR_ERR_NONE;
        end else if (!regDefined) begin
            // RL18 register not defined
            errCode = `SCR_ERR_REG;
        end else if (isBcast && startReg != `SCR_BCAST_REG_LO
                && startReg != `SCR_BCAST_REG_HI) begin
            // RL19 broadcast start register
            errCode = `SCR_ERR_REG;
        end else if (!isWrite && nonConsecutive && readBytes > `SCR_READ_MAX_BYTES) begin
            // RL1 read size limit
            errCode = `SCR_ERR_COUNT;
        end else if (isWrite && nonConsecutive && byteCount > `SCR_WRITE_MAX_BYTES) begin
            // RL2 write size limit
            errCode = `SCR_ERR_COUNT;
        end else if (isWrite) begin
            if (regReadOnly) begin
                // RL6 read-only item
                errCode = `SCR_ERR_MODE;
            end else if (regRunLocked && motorRunning) begin
                // RL4 locked during run
                errCode = `SCR_ERR_MODE;
            end else if (controlCircuitFault && !regSetupItem) begin
                // RL5 fault allows setup items only
                errCode = `SCR_ERR_MODE;
            end else if (dcBusUndervoltage && regUvLocked) begin
                // RL7 undervoltage lock
                errCode = `SCR_ERR_UV;
            end else if (paramBusy) begin
                // RL8 drive still processing
                errCode = `SCR_ERR_BUSY;
            end else if (nvStoreCmd && nvWriteDisabled) begin
                // RL9 nonvolatile store disabled
                errCode = `SCR_ERR_NVM;
            end else if (!valueInRange) begin
                // RL3 setting out of range
                errCode = `SCR_ERR_DATA;
            end
        end
    end

    // ====================================================
    // answer and monitor registers
    logic respValid_ff, nxt_respValid;
    logic respIsError_ff, nxt_respIsError;
    logic [7:0] respCode_ff, nxt_respCode;
    logic execStrobe_ff, nxt_execStrobe;
    logic discard_ff, nxt_discard;
    logic [7:0] monCode_ff, nxt_monCode;
    err_type_type monType_ff, nxt_monType;
    logic nvWarn_ff, nxt_nvWarn;

    // next answer values, evaluated at frame end
    always_comb begin
        nxt_respValid = 1'b0;
        nxt_respIsError = respIsError_ff;
        nxt_respCode = respCode_ff;
        nxt_execStrobe = 1'b0;
        nxt_discard = 1'b0;
        nxt_monCode = monCode_ff;
        nxt_monType = monType_ff;
        // operator acknowledge clears the message
        nxt_nvWarn = nvWarn_ff & !nvWarnAck;
        if (frameDone) begin
            if (lineBad) begin
                // RL11 drop without reply, keep the cause
                nxt_discard = 1'b1;
                nxt_monType = ET_LINK;
            end else if (!addrHit) begin
                // RL12 not for this slave
                nxt_discard = 1'b1;
            end else if (isBcast) begin
                // RL15 broadcast never answers
                nxt_execStrobe = isWrite && (errCode == `SCR_ERR_NONE);
                if (errCode != `SCR_ERR_NONE) begin
                    nxt_monCode = errCode;
                    nxt_monType = ET_BROADCAST;
                end
            end else begin
                // RL20 normal or error answer
                nxt_respValid = 1'b1;
                nxt_respIsError = (errCode != `SCR_ERR_NONE);
                nxt_respCode = errCode;
                nxt_execStrobe = (errCode == `SCR_ERR_NONE);
                if (errCode != `SCR_ERR_NONE) begin
                    // RL16 keep last code and type
                    nxt_monCode = errCode;
                    nxt_monType = ET_ANSWERED;
                end
            end
            // RL10 message only, the drive runs on
            if (!lineBad && addrHit && errCode == `SCR_ERR_NVM) begin
                nxt_nvWarn = 1'b1;
            end
        end
    end

    // register answers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            respValid_ff <= 1'b0;
            respIsError_ff <= 1'b0;
            respCode_ff <= `SCR_ERR_NONE;
            execStrobe_ff <= 1'b0;
            discard_ff <= 1'b0;
            monCode_ff <= `SCR_ERR_NONE;
            monType_ff <= ET_NONE;
            nvWarn_ff <= 1'b0;
        end else begin
            respValid_ff <= nxt_respValid;
            respIsError_ff <= nxt_respIsError;
            respCode_ff <= nxt_respCode;
            execStrobe_ff <= nxt_execStrobe;
            discard_ff <= nxt_discard;
            monCode_ff <= nxt_monCode;
            monType_ff <= nxt_monType;
            nvWarn_ff <= nxt_nvWarn;
        end
    end

    // outputs straight from flip-flops
    assign respValid = respValid_ff;
    assign respIsError = respIsError_ff;
    assign respCode = respCode_ff;
    assign execStrobe = execStrobe_ff;
    assign discardStrobe = discard_ff;
    assign commErrCode = monCode_ff;
    assign commErrType = monType_ff;
    assign nvWarnMsg = nvWarn_ff;

    // ====================================================
    // checks
    sequence s_goodUnicast;
        frameDone && crcOk && lengthOk && !charErrSeen_ff && !gapSeen_ff
            && !charError && slaveAddr == nodeAddress && !isBcast;
    endsequence

    sequence s_errAnswer(logic [7:0] code);
        respValid_ff && respIsError_ff && respCode_ff == code;
    endsequence

    property p_crcDrop;
        @(posedge clk_sys) disable iff (rst)
        frameDone && !crcOk |=> discard_ff && !respValid_ff
            ##1 (!respValid_ff || $past(frameDone));
    endproperty
    a_crcDrop: assert property (p_crcDrop) else $error("bad checksum frame answered"); // RL11

    property p_addrIgnore;
        @(posedge clk_sys) disable iff (rst)
        frameDone && slaveAddr != nodeAddress && !isBcast |=> !respValid_ff && !execStrobe_ff;
    endproperty
    a_addrIgnore: assert property (p_addrIgnore) else $error("foreign frame acted on"); // RL12

    property p_gapDrop;
        @(posedge clk_sys) disable iff (rst)
        frameDone && gapSeen_ff |=> discard_ff && !respValid_ff;
    endproperty
    a_gapDrop: assert property (p_gapDrop) else $error("gapped frame not dropped"); // RL13

    property p_bcastSilent;
        @(posedge clk_sys) disable iff (rst)
        frameDone && isBcast |=> !respValid_ff ##1 (!respValid_ff || $past(frameDone));
    endproperty
    a_bcastSilent: assert property (p_bcastSilent) else $error("broadcast answered"); // RL15

    property p_funcErr;
        @(posedge clk_sys) disable iff (rst)
        s_goodUnicast and (funcCode != `SCR_FC_READ && funcCode != `SCR_FC_LOOP
            && funcCode != `SCR_FC_WRITE) |=> s_errAnswer(`SCR_ERR_FUNC);
    endproperty
    a_funcErr: assert property (p_funcErr) else $error("function error not answered"); // RL17

    property p_regErr;
        @(posedge clk_sys) disable iff (rst)
        s_goodUnicast and funcCode == `SCR_FC_READ and !regDefined
            |=> s_errAnswer(`SCR_ERR_REG);
    endproperty
    a_regErr: assert property (p_regErr) else $error("register error not answered"); // RL18

    property p_runLock;
        @(posedge clk_sys) disable iff (rst)
        s_goodUnicast and isWrite && regDefined && !regReadOnly && !nonConsecutive
            && regRunLocked && motorRunning |=> s_errAnswer(`SCR_ERR_MODE);
    endproperty
    a_runLock: assert property (p_runLock) else $error("run lock not answered"); // RL4

    property p_nvmWarn;
        @(posedge clk_sys) disable iff (rst)
        respValid_ff && respCode_ff == `SCR_ERR_NVM |-> nvWarnMsg && respIsError_ff;
    endproperty
    a_nvmWarn: assert property (p_nvmWarn) else $error("store error gave no message"); // RL10

    property p_monitor;
        @(posedge clk_sys) disable iff (rst)
        respValid_ff && respIsError_ff |-> commErrCode == respCode_ff
            && commErrType == ET_ANSWERED
            ##1 (commErrCode == $past(respCode_ff) || $past(frameDone));
    endproperty
    a_monitor: assert property (p_monitor) else $error("monitor lost error code"); // RL16
endmodule

// ---- pkg/serial_screen_defs.svh ----
// constants for the serial slave request screening block
`ifndef SERIAL_SCREEN_DEFS_SVH
`define SERIAL_SCREEN_DEFS_SVH

// system clock rate in hertz
`define SCR_CLK_HZ 50000000
// default line rate in baud, a plain choice
`define SCR_BAUD_DEFAULT 9600
// longest legal gap between characters, in bit times
`define SCR_GAP_BITS 24

// accepted function codes
`define SCR_FC_READ 8'h03
`define SCR_FC_LOOP 8'h08
`define SCR_FC_WRITE 8'h10

// broadcast address and the starting registers it may use
`define SCR_BCAST_ADDR 8'h00
`define SCR_BCAST_REG_LO 16'h0001
`define SCR_BCAST_REG_HI 16'h0002

// byte limits for non-consecutive register access
`define SCR_READ_MAX_BYTES 9'h078
`define SCR_WRITE_MAX_BYTES 8'h3c

// error response codes
`define SCR_ERR_NONE 8'h00
`define SCR_ERR_FUNC 8'h01
`define SCR_ERR_REG 8'h02
`define SCR_ERR_COUNT 8'h03
`define SCR_ERR_DATA 8'h21
`define SCR_ERR_MODE 8'h22
`define SCR_ERR_UV 8'h23
`define SCR_ERR_BUSY 8'h24
`define SCR_ERR_NVM 8'h25

`endif

// ---- pkg/serial_screen_pkg.sv ----
// types shared by the serial slave request screening block
package serial_screen_pkg;

    // frame receive state
    typedef enum logic [0:0] {
        RX_IDLE = 1'b0,
        RX_BUSY = 1'b1
    } rx_state_type;

    // kind of the last recorded communication error
    typedef enum logic [1:0] {
        ET_NONE = 2'b00,
        ET_LINK = 2'b01,
        ET_ANSWERED = 2'b10,
        ET_BROADCAST = 2'b11
    } err_type_type;

endpackage

// ---- hw/gap_timer.sv ----
// counter of clock cycles since the last received character
`timescale 1ns/10ps
module gap_timer #(
    parameter int LIMIT = 125000,
    parameter int CNT_W = 18
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic charStrobe,
    input wire logic frameActive,
    output logic gapOver
);
    // cycles since the last character, saturating above the limit
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;

    // ====================================================
    // next count
    always_comb begin
        nxt_cnt = cnt_ff;
        if (charStrobe || !frameActive) begin
            // restart at every character and outside frames
            nxt_cnt = '0;
        end else if (cnt_ff <= CNT_W'(LIMIT)) begin
            nxt_cnt = cnt_ff + 1'b1;
        end
    end

    // register the count
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    // gap longer than the limit
    assign gapOver = (cnt_ff > CNT_W'(LIMIT));
endmodule

// ---- test/modbus_master_model.sv ----
// bus master model that sends command frames to the slave
`timescale 1ns/10ps
module modbus_master_model (
    input wire logic clk_sys,
    output logic charStrobe,
    output logic charError,
    output logic frameDone,
    output logic crcOk,
    output logic lengthOk,
    output logic [7:0] slaveAddr,
    output logic [7:0] funcCode,
    output logic [15:0] startReg,
    output logic [7:0] regCount,
    output logic [7:0] byteCount,
    output logic nonConsecutive
);
    // ========================================
    // idle lines before the first frame
    initial begin
        {charStrobe, charError, frameDone} = 3'h0;
        {crcOk, lengthOk, nonConsecutive} = 3'h0;
        {slaveAddr, funcCode, startReg, regCount, byteCount} = 48'h0;
    end

    // ========================================
    // one frame: three characters, then the frame end with its fields
    // fl is {non-consecutive, char error, crc good, length good}
    task automatic sendFrame(input logic [7:0] adr, input logic [7:0] fc,
        input logic [15:0] sr, input logic [7:0] rc, input logic [7:0] bc,
        input logic [3:0] fl, input int gap);
        for (int i = 0; i < 3; i++) begin
            @(posedge clk_sys) #1;
            charStrobe = 1'b1;
            // line error rides on the last character
            charError = fl[2] && (i == 2);
            @(posedge clk_sys) #1;
            charStrobe = 1'b0;
            charError = 1'b0;
            // idle gap between characters
            if (i < 2) repeat (gap) @(posedge clk_sys);
        end
        @(posedge clk_sys) #1;
        frameDone = 1'b1;
        {nonConsecutive, crcOk, lengthOk} = {fl[3], fl[1], fl[0]};
        {slaveAddr, funcCode, startReg, regCount, byteCount} = {adr, fc, sr, rc, bc};
        @(posedge clk_sys) #1;
        frameDone = 1'b0;
        // released fields no longer show the last value
        {nonConsecutive, crcOk, lengthOk} = ~{nonConsecutive, crcOk, lengthOk};
        {slaveAddr, funcCode, startReg} = ~{slaveAddr, funcCode, startReg};
        {regCount, byteCount} = ~{regCount, byteCount};
    endtask
endmodule

// ---- test/tb_top.sv ----
// self-checking bench for the serial slave request screening block
`timescale 1ns/10ps
`include "serial_screen_defs.svh"
module tb_top;
    logic clk_sys, rst, nvWarnAck;
    logic charStrobe, charError, frameDone, crcOk, lengthOk, nonConsecutive;
    logic [7:0] slaveAddr, funcCode, regCount, byteCount, respCode, commErrCode;
    logic [15:0] startReg;
    logic [7:0] node; // configured node address of the slave
    logic [6:0] at; // item attributes, defined downto nv store
    logic [4:0] st; // run, fault, undervoltage, busy, nv disabled
    logic respValid, respIsError, execStrobe, discardStrobe, nvWarnMsg;
    logic [1:0] commErrType;
    int n_fail = 0;
    int total_checks = 0;
    localparam logic [7:0] NODE = 8'h11;
    localparam logic [6:0] A_OK = 7'h42;
    localparam logic [3:0] FL_OK = 4'h3;
    localparam logic [47:0] FCS = 48'h030810_0500ff;
    localparam logic [55:0] WA = {7'h62, 7'h52, 7'h42, 7'h46, 7'h4a, 7'h42, 7'h43, 7'h40};
    localparam logic [39:0] WS = {5'h00, 5'h10, 5'h08, 5'h08, 5'h04, 5'h02, 5'h01, 5'h00};
    localparam logic [63:0] WC = 64'h22222200_23242521;

    // ========================================
    // clock, far side and device under test
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    modbus_master_model master (.clk_sys(clk_sys), .charStrobe(charStrobe),
        .charError(charError), .frameDone(frameDone), .crcOk(crcOk), .lengthOk(lengthOk),
        .slaveAddr(slaveAddr), .funcCode(funcCode), .startReg(startReg),
        .regCount(regCount), .byteCount(byteCount), .nonConsecutive(nonConsecutive));
    serial_slave_error_screening #(.GAP_CYCLES(50)) dut (.clk_sys(clk_sys), .rst(rst),
        .charStrobe(charStrobe), .charError(charError), .frameDone(frameDone),
        .crcOk(crcOk), .lengthOk(lengthOk), .slaveAddr(slaveAddr), .funcCode(funcCode),
        .startReg(startReg), .regCount(regCount), .byteCount(byteCount),
        .nonConsecutive(nonConsecutive), .regDefined(at[6]), .regReadOnly(at[5]),
        .regRunLocked(at[4]), .regUvLocked(at[3]), .regSetupItem(at[2]),
        .valueInRange(at[1]), .nvStoreCmd(at[0]), .nodeAddress(node),
        .motorRunning(st[4]), .controlCircuitFault(st[3]), .dcBusUndervoltage(st[2]),
        .paramBusy(st[1]), .nvWriteDisabled(st[0]), .nvWarnAck(nvWarnAck),
        .respValid(respValid), .respIsError(respIsError), .respCode(respCode),
        .execStrobe(execStrobe), .discardStrobe(discardStrobe),
        .commErrCode(commErrCode), .commErrType(commErrType), .nvWarnMsg(nvWarnMsg));

    // ========================================
    // shared helpers
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // send a frame; attributes are scrambled once the answer edge has passed
    task automatic frame(input logic [7:0] adr, input logic [7:0] fc, input logic [15:0] sr,
        input logic [7:0] rc, input logic [7:0] bc, input logic [6:0] a,
        input logic [3:0] fl, input int gap);
        at = a;
        master.sendFrame(adr, fc, sr, rc, bc, fl, gap);
        at = ~at;
    endtask
    // judge the answer cycle
    task automatic ans(input logic v, input logic [7:0] code, input logic x, input logic d);
        chk("respValid", respValid, v);
        chk("execStrobe", execStrobe, x);
        chk("discardStrobe", discardStrobe, d);
        if (v) begin
            chk("respIsError", respIsError, code != 8'h00);
            chk("respCode", respCode, code);
        end
    endtask

    // ========================================
    // scenarios
    task automatic t_reset();
        chk("respValid", respValid, 1'b0);
        chk("commErrCode", commErrCode, 8'h00);
        chk("commErrType", commErrType, 2'h0);
        chk("nvWarnMsg", nvWarnMsg, 1'b0);
    endtask
    task automatic t_func();
        for (int i = 0; i < 6; i++) begin
            frame(NODE, FCS[47-8*i -: 8], 16'h0010, 8'h01, 8'h02, A_OK, FL_OK, 0);
            ans(1'b1, (i < 3) ? `SCR_ERR_NONE : `SCR_ERR_FUNC, i < 3, 1'b0);
        end
    endtask
    task automatic t_reg();
        frame(NODE, `SCR_FC_READ, 16'h7fff, 8'h01, 8'h00, 7'h02, FL_OK, 0);
        ans(1'b1, `SCR_ERR_REG, 1'b0, 1'b0);
        frame(`SCR_BCAST_ADDR, `SCR_FC_WRITE, `SCR_BCAST_REG_LO, 8'h01, 8'h02, A_OK, FL_OK, 0);
        ans(1'b0, 8'h00, 1'b1, 1'b0);
        frame(`SCR_BCAST_ADDR, `SCR_FC_WRITE, `SCR_BCAST_REG_HI, 8'h01, 8'h02, A_OK, FL_OK, 0);
        ans(1'b0, 8'h00, 1'b1, 1'b0);
        frame(`SCR_BCAST_ADDR, `SCR_FC_WRITE, 16'h0003, 8'h01, 8'h02, A_OK, FL_OK, 0);
        ans(1'b0, 8'h00, 1'b0, 1'b0);
        chk("commErrCode", commErrCode, `SCR_ERR_REG);
        chk("commErrType", commErrType, 2'h3);
    endtask
    task automatic t_count();
        frame(NODE, `SCR_FC_READ, 16'h0010, 8'h3c, 8'h00, A_OK, 4'hb, 0);
        ans(1'b1, `SCR_ERR_NONE, 1'b1, 1'b0);
        frame(NODE, `SCR_FC_READ, 16'h0010, 8'h3d, 8'h00, A_OK, 4'hb, 0);
        ans(1'b1, `SCR_ERR_COUNT, 1'b0, 1'b0);
        frame(NODE, `SCR_FC_READ, 16'h0010, 8'h3d, 8'h00, A_OK, FL_OK, 0);
        ans(1'b1, `SCR_ERR_NONE, 1'b1, 1'b0);
        frame(NODE, `SCR_FC_WRITE, 16'h0010, 8'h1e, 8'h3c, A_OK, 4'hb, 0);
        ans(1'b1, `SCR_ERR_NONE, 1'b1, 1'b0);
        frame(NODE, `SCR_FC_WRITE, 16'h0010, 8'h1f, 8'h3d, A_OK, 4'hb, 0);
        ans(1'b1, `SCR_ERR_COUNT, 1'b0, 1'b0);
    endtask
    task automatic t_write();
        logic [7:0] code;
        for (int i = 0; i < 8; i++) begin
            st = WS[39-5*i -: 5];
            code = WC[63-8*i -: 8];
            frame(NODE, `SCR_FC_WRITE, 16'h0100, 8'h01, 8'h02, WA[55-7*i -: 7], FL_OK, 0);
            ans(1'b1, code, code == 8'h00, 1'b0);
            if (code != 8'h00) begin
                chk("commErrCode", commErrCode, code);
                chk("commErrType", commErrType, 2'h2);
            end
        end
        st = 5'h10;
    endtask
    task automatic t_nvwarn();
        chk("nvWarnMsg", nvWarnMsg, 1'b1);
        @(posedge clk_sys) #1;
        nvWarnAck = 1'b1;
        @(posedge clk_sys) #1;
        nvWarnAck = 1'b0;
        chk("nvWarnMsg", nvWarnMsg, 1'b0);
    endtask
    task automatic t_line();
        frame(NODE, `SCR_FC_READ, 16'h0010, 8'h01, 8'h00, A_OK, 4'h7, 0);
        ans(1'b0, 8'h00, 1'b0, 1'b1);
        chk("commErrType", commErrType, 2'h1);
        chk("commErrCode", commErrCode, `SCR_ERR_DATA);
        frame(NODE, `SCR_FC_READ, 16'h0010, 8'h01, 8'h00, A_OK, 4'h1, 0);
        ans(1'b0, 8'h00, 1'b0, 1'b1);
        frame(NODE, `SCR_FC_READ, 16'h0010, 8'h01, 8'h00, A_OK, 4'h2, 0);
        chk("respValid", respValid, 1'b0);
        chk("execStrobe", execStrobe, 1'b0);
        chk("discardStrobe", discardStrobe, 1'b1);
        frame(8'h12, `SCR_FC_READ, 16'h0010, 8'h01, 8'h00, A_OK, FL_OK, 0);
        ans(1'b0, 8'h00, 1'b0, 1'b1);
        chk("commErrCode", commErrCode, `SCR_ERR_DATA);
        node = 8'h12;
        frame(8'h12, `SCR_FC_READ, 16'h0010, 8'h01, 8'h00, A_OK, FL_OK, 0);
        ans(1'b1, 8'h00, 1'b1, 1'b0);
        node = NODE;
        frame(NODE, `SCR_FC_READ, 16'h0010, 8'h01, 8'h00, A_OK, FL_OK, 60);
        ans(1'b0, 8'h00, 1'b0, 1'b1);
        frame(NODE, `SCR_FC_READ, 16'h0010, 8'h01, 8'h00, A_OK, FL_OK, 40);
        ans(1'b1, 8'h00, 1'b1, 1'b0);
    endtask

    // ========================================
    // verdict, main sequence and watchdog
    task automatic finish_test();
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        rst = 1'b1;
        nvWarnAck = 1'b0;
        st = 5'h00;
        at = A_OK;
        node = NODE;
        repeat (16) @(posedge clk_sys);
        #1 rst = 1'b0;
        t_reset();
        t_func();
        t_reg();
        t_count();
        t_write();
        t_nvwarn();
        t_line();
        finish_test();
    end
    // runs far past the roughly 460 cycles the scenarios need
    initial begin
        #400000;
        n_fail++;
        finish_test();
    end
endmodule
